/* File: shared/fic_params.svh */
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH
// Register byte offsets
`define FIC_OFF_MASKED 12'h100
`define FIC_OFF_RAW 12'h104
`define FIC_OFF_EN_SET 12'h108
`define FIC_OFF_EN_CLR 12'h10C
`define FIC_OFF_TRIG 12'h180
`define FIC_OFF_POL 12'h184
`define FIC_OFF_EDGE_CLR 12'h188
`define FIC_OFF_EVT_STAT 12'h190
`define FIC_OFF_EVT_MASK 12'h194
// Reset values
`define FIC_RST_EN 2'h0
`define FIC_RST_TRIG 2'h0
`define FIC_RST_POL 2'h3
`define FIC_RST_EVT 2'h0
`endif

/* File: shared/fic_pkg.sv */
package fic_pkg;
  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fic_apb_req_t;
endpackage : fic_pkg

/* File: rtl/fic_top.sv */
`timescale 1ns/1ps
`include "fic_params.svh"
module fic_top #(
  parameter int NSRC = 2
) (
  input wire logic sys_clk, // System clock 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire fic_pkg::fic_apb_req_t apb_req, // APB request
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic [31:0] prdata, // APB read data
  input wire logic [NSRC-1:0] src_req, // Raw request inputs
  output logic fast_interrupt_line, // Fast request to core
  output logic evt_irq // Event interrupt output
);
  // Only two sources fit the register layout; refuse others at elaboration
  if (NSRC != 2) begin : g_nsrc_bad
    $error("fic_top supports NSRC of 2 only");
  end

  logic [NSRC-1:0] sync1_r; // First sync stage
  logic [NSRC-1:0] sync2_r; // Second sync stage
  logic [NSRC-1:0] prev_r; // Previous sample for edges
  logic [NSRC-1:0] en_r; // Enable bits
  logic [NSRC-1:0] trig_r; // Trigger type, 1 edge
  logic [NSRC-1:0] pol_r; // Polarity, 1 high/rising
  logic [NSRC-1:0] edge_lat_r; // Latched edge requests
  logic [NSRC-1:0] evt_stat_r; // Sticky event status
  logic [NSRC-1:0] evt_mask_r; // Event mask
  logic [NSRC-1:0] act; // Request at active polarity
  logic [NSRC-1:0] act_prev; // Previous active level
  logic [NSRC-1:0] edge_hit; // Active edge this cycle
  logic [NSRC-1:0] raw; // Raw status
  logic [NSRC-1:0] masked; // Masked status
  logic [NSRC-1:0] rise_raw; // Raw status newly set
  logic [NSRC-1:0] raw_prev_r; // Raw one cycle ago
  logic wr_acc; // Write access phase
  logic rd_acc; // Read access phase
  logic [11:0] addr; // Byte address

  assign addr = apb_req.paddr;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  // Two-flop synchroniser; first stage read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      sync1_r <= src_req;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Polarity folds low/falling into high/rising
  assign act = ~(sync2_r ^ pol_r);
  assign act_prev = ~(prev_r ^ pol_r);
  // Edge from successive samples; both use today's polarity, so a polarity write fakes none
  assign edge_hit = act & ~act_prev;

  // Edge latch; a new edge wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_lat_r <= 2'h0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (trig_r[i] && edge_hit[i]) begin
          edge_lat_r[i] <= 1'b1;
        end else if (wr_acc && addr == `FIC_OFF_EDGE_CLR && apb_req.pwdata[i]) begin
          edge_lat_r[i] <= 1'b0;
        end else if (!trig_r[i]) begin
          edge_lat_r[i] <= 1'b0; // Level mode keeps no latch
        end
      end
    end
  end

  // Raw follows level in level mode, latch in edge mode
  assign raw = (trig_r & edge_lat_r) | (~trig_r & act);
  assign masked = raw & en_r;
  assign fast_interrupt_line = |masked;

  // Enable set and clear; set is tested first, but the two offsets never meet in one write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= `FIC_RST_EN;
    end else if (wr_acc && addr == `FIC_OFF_EN_SET) begin
      en_r <= en_r | apb_req.pwdata[NSRC-1:0];
    end else if (wr_acc && addr == `FIC_OFF_EN_CLR) begin
      en_r <= en_r & ~apb_req.pwdata[NSRC-1:0];
    end
  end

  // Trigger type and polarity configuration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_r <= `FIC_RST_TRIG;
      pol_r <= `FIC_RST_POL;
    end else begin
      if (wr_acc && addr == `FIC_OFF_TRIG) begin
        trig_r <= apb_req.pwdata[NSRC-1:0];
      end
      if (wr_acc && addr == `FIC_OFF_POL) begin
        pol_r <= apb_req.pwdata[NSRC-1:0];
      end
    end
  end

  // Event status: sets on raw rising, read clears, set wins
  assign rise_raw = raw & ~raw_prev_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_prev_r <= 2'h0;
      evt_stat_r <= `FIC_RST_EVT;
      evt_mask_r <= `FIC_RST_EVT;
    end else begin
      raw_prev_r <= raw;
      if (rd_acc && addr == `FIC_OFF_EVT_STAT) begin
        // Clear only what the setup edge captured; later sets survive
        evt_stat_r <= (evt_stat_r & ~prdata[NSRC-1:0]) | rise_raw;
      end else begin
        evt_stat_r <= evt_stat_r | rise_raw;
      end
      if (wr_acc && addr == `FIC_OFF_EVT_MASK) begin
        evt_mask_r <= apb_req.pwdata[NSRC-1:0];
      end
    end
  end
  assign evt_irq = |(evt_stat_r & evt_mask_r);

  // Zero-wait slave; unmapped reads give zero and an error
  assign pready = 1'b1;
  always_comb begin
    pslverr = 1'b0;
    case (addr)
      `FIC_OFF_MASKED, `FIC_OFF_RAW, `FIC_OFF_EN_SET, `FIC_OFF_EN_CLR,
      `FIC_OFF_TRIG, `FIC_OFF_POL, `FIC_OFF_EDGE_CLR,
      `FIC_OFF_EVT_STAT, `FIC_OFF_EVT_MASK: pslverr = 1'b0;
      default: pslverr = apb_req.psel && apb_req.penable;
    endcase
  end

  // Read data registered at the setup phase for the access edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      case (addr)
        `FIC_OFF_MASKED: prdata <= {30'h0, masked};
        `FIC_OFF_RAW: prdata <= {30'h0, raw};
        `FIC_OFF_EN_SET: prdata <= {30'h0, en_r};
        `FIC_OFF_TRIG: prdata <= {30'h0, trig_r};
        `FIC_OFF_POL: prdata <= {30'h0, pol_r};
        `FIC_OFF_EVT_STAT: prdata <= {30'h0, evt_stat_r};
        `FIC_OFF_EVT_MASK: prdata <= {30'h0, evt_mask_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks; each names its own clock and reset, as the reset-value check
  // must look inside reset, where a shared default disable would hide it

  // Read data is captured on the setup edge, so in the access phase it
  // equals what raw AND enable were one edge back
  masked_and_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_MASKED |-> prdata[1:0] == $past(raw & en_r))
    else $error("masked status read wrong");

  // Line checked against source terms built from enables, mode, polarity, synchronised pins and latches
  line_any_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fast_interrupt_line == (
      (en_r[0] && !trig_r[0] && sync2_r[0] == pol_r[0]) ||
      (en_r[0] && trig_r[0] && edge_lat_r[0]) ||
      (en_r[1] && !trig_r[1] && sync2_r[1] == pol_r[1]) ||
      (en_r[1] && trig_r[1] && edge_lat_r[1])))
    else $error("line does not follow enabled sources");

  // A raw bit falling takes its masked bit down in the same cycle
  raw_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(raw[0]) |-> !masked[0])
    else $error("masked bit 0 stuck");

  // Same for the second source
  raw_clr1_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(raw[1]) |-> !masked[1])
    else $error("masked bit 1 stuck");

  // Level mode: raw tracks the synchronised pin at the chosen polarity
  level_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !trig_r[0] |-> raw[0] == (sync2_r[0] == pol_r[0]))
    else $error("level source not followed");

  // Edge mode: a latch holds until software clears it
  edge_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_r[0] && edge_lat_r[0] && !wr_acc |=> edge_lat_r[0])
    else $error("edge latch lost");

  // An active edge in edge mode always latches
  edge_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_r[1] && edge_hit[1] |=> edge_lat_r[1])
    else $error("edge not latched");

  // Level mode keeps no latch, so raw cannot stick after a mode switch
  edge_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !trig_r[1] |=> !edge_lat_r[1])
    else $error("latch held in level mode");

  // A trigger-reset one clears the latch unless a new edge lands with it
  edge_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_acc && addr == `FIC_OFF_EDGE_CLR && apb_req.pwdata[1] && trig_r[1] && !edge_hit[1]
    |=> !edge_lat_r[1])
    else $error("edge clear failed");

  // Polarity zero in edge mode catches a falling pin
  pol_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trig_r[0] && !pol_r[0] && $fell(sync2_r[0]) |-> edge_hit[0])
    else $error("falling edge missed");

  // A write of ones sets those enables
  en_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_acc && addr == `FIC_OFF_EN_SET |=>
    (en_r & $past(apb_req.pwdata[1:0])) == $past(apb_req.pwdata[1:0]))
    else $error("enable set");

  // A clear write of ones masks those sources
  en_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_acc && addr == `FIC_OFF_EN_CLR |=> (en_r & $past(apb_req.pwdata[1:0])) == 2'h0)
    else $error("enable clear");

  // Enables move only on a write to one of their two registers
  en_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr_acc && (addr == `FIC_OFF_EN_SET || addr == `FIC_OFF_EN_CLR)) |=> $stable(en_r))
    else $error("enables changed without a write");

  // Configuration and enables right after a reset edge
  rst_val_a: assert property (@(posedge sys_clk)
    !rst_n |=> en_r == `FIC_RST_EN && trig_r == `FIC_RST_TRIG && pol_r == `FIC_RST_POL)
    else $error("reset values wrong");

  // Enables read back as they stand
  rd_en_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_EN_SET |-> prdata[1:0] == $past(en_r))
    else $error("enable read wrong");

  // Raw status reads back whatever the enables say, as raw ignores them
  rd_raw_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_RAW |-> prdata[1:0] == $past(raw))
    else $error("raw status read wrong");

  // Trigger type reads back
  rd_trig_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_TRIG |-> prdata[1:0] == $past(trig_r))
    else $error("trigger type read wrong");

  // Polarity reads back
  rd_pol_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_POL |-> prdata[1:0] == $past(pol_r))
    else $error("polarity read wrong");

  // Write-only registers read as zero
  rd_wo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && (addr == `FIC_OFF_EN_CLR || addr == `FIC_OFF_EDGE_CLR)
    |-> prdata == 32'h0000_0000)
    else $error("write-only register read nonzero");

  // Unused upper bits always read as zero
  rd_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc |-> prdata[31:2] == 30'h0)
    else $error("upper read bits nonzero");

  // Trigger-type write lands on the access edge
  trig_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_acc && addr == `FIC_OFF_TRIG |=> trig_r == $past(apb_req.pwdata[1:0]))
    else $error("trigger type write lost");

  // Polarity write lands on the access edge
  pol_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_acc && addr == `FIC_OFF_POL |=> pol_r == $past(apb_req.pwdata[1:0]))
    else $error("polarity write lost");

  // A raw rising reaches the event status, even during its read
  evt_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rise_raw[0] |=> evt_stat_r[0])
    else $error("event lost");

  // A read with no raw rising clears the bits that it reported
  evt_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_acc && addr == `FIC_OFF_EVT_STAT && rise_raw == 2'h0 |=>
    (evt_stat_r & $past(prdata[1:0])) == 2'h0)
    else $error("event read did not clear");

  // Error only in an access phase
  err_phase_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(apb_req.psel && apb_req.penable) |-> !pslverr)
    else $error("error outside access phase");

  // Requests reach the edge logic two edges after the pin
  sync_lat_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sync2_r == $past(src_req, 2))
    else $error("sync latency");

  // Main scenarios
  edge_cov_c: cover property (@(posedge sys_clk) trig_r[0] && edge_hit[0]);
  line_cov_c: cover property (@(posedge sys_clk) $rose(fast_interrupt_line));
  evt_cov_c: cover property (@(posedge sys_clk) $rose(evt_irq));
  fall_cov_c: cover property (@(posedge sys_clk) trig_r[0] && !pol_r[0] && edge_hit[0]);
  clr_cov_c: cover property (@(posedge sys_clk)
    wr_acc && addr == `FIC_OFF_EDGE_CLR && (apb_req.pwdata[1:0] & edge_lat_r) != 2'h0);
endmodule : fic_top

/* File: sim/fic_core_model.sv */
`timescale 1ns/1ps
// Stands in for the core: counts each fast request it would take
module fic_core_model (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic irq_line, // Fast request from controller
  output int n_irq // Requests taken
);
  logic seen_r; // Line level one cycle ago
  // A level line: only the rising of it starts a handler
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      n_irq <= 0;
    end else begin
      seen_r <= irq_line;
      if (irq_line && !seen_r) begin
        n_irq <= n_irq + 1;
      end
    end
  end
endmodule : fic_core_model

/* File: sim/fast_interrupt_controller_test.sv */
`timescale 1ns/1ps
module fast_interrupt_controller_test;
  logic sys_clk, rst_n, pready, pslverr, line, evt_irq, err; // Clock, reset, outputs
  logic [1:0] src, s, e; // Requests and random picks
  logic [31:0] prdata, rd; // Read data, last word read
  fic_pkg::fic_apb_req_t req; // APB request
  int n_mismatch, n_checks, n_irq, cyc = 0; // Counters
  fic_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .src_req(src), .fast_interrupt_line(line),
    .evt_irq(evt_irq));
  fic_core_model core_u (.sys_clk(sys_clk), .rst_n(rst_n), .irq_line(line), .n_irq(n_irq));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Count and report one comparison
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; waits on pready, only the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk
  // Expected raw word of level sources at a given polarity
  function automatic logic [31:0] lvl_word(input logic [1:0] v, input logic [1:0] p);
    return {30'h0, ~(v ^ p)};
  endfunction : lvl_word
  // Request change needs two to three edges to reach the raw bits
  task automatic drive(input logic [1:0] v);
    src <= v;
    repeat (4) @(posedge sys_clk);
  endtask : drive
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    req = '0;
    src = 2'h0;
    rst_n = 1'b0;
    void'($urandom(32'h5C63));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk("enable", 12'h108, 32'h0);
    rdchk("trigger", 12'h180, 32'h0);
    rdchk("polarity", 12'h184, 32'h3);
    // Random levels and enables; upper write bits must not stick
    for (int i = 0; i < 12; i++) begin
      s = 2'($urandom);
      e = 2'($urandom);
      src <= s;
      apb(1'b1, 12'h10C, 32'h3);
      apb(1'b1, 12'h108, {30'h3FFF_FFFF, e});
      apb(1'b1, 12'h108, 32'h0);
      rdchk("enable", 12'h108, {30'h0, e});
      rdchk("raw", 12'h104, lvl_word(s, 2'h3));
      rdchk("masked", 12'h100, {30'h0, s & e});
      chk("line", {31'h0, line}, {31'h0, |(s & e)});
      apb(1'b1, 12'h10C, 32'h1);
      rdchk("enclr", 12'h108, {30'h0, e & 2'h2});
    end
    apb(1'b1, 12'h184, 32'h0);
    drive(s);
    rdchk("lowpol", 12'h104, lvl_word(s, 2'h0));
    // Edge mode: pulse both, latch survives a zero clear, one clears
    apb(1'b1, 12'h184, 32'h3);
    apb(1'b1, 12'h180, 32'h3);
    drive(2'h0);
    apb(1'b1, 12'h188, 32'h3);
    drive(2'h3);
    drive(2'h0);
    rdchk("latch", 12'h104, 32'h3);
    apb(1'b1, 12'h188, 32'h0);
    rdchk("clr0", 12'h104, 32'h3);
    apb(1'b1, 12'h108, 32'h1);
    rdchk("masked", 12'h100, {30'h0, e | 2'h1});
    apb(1'b1, 12'h188, 32'h1);
    rdchk("clr1", 12'h104, 32'h2);
    rdchk("mclr", 12'h100, {30'h0, e & 2'h2});
    // Level mode ignores edge clear
    apb(1'b1, 12'h180, 32'h0);
    drive(2'h3);
    apb(1'b1, 12'h188, 32'h3);
    rdchk("lvlclr", 12'h104, 32'h3);
    // Falling edge: polarity zero in edge mode latches on a drop
    apb(1'b1, 12'h184, 32'h0);
    apb(1'b1, 12'h180, 32'h3);
    apb(1'b1, 12'h188, 32'h3);
    drive(2'h0);
    rdchk("fall", 12'h104, 32'h3);
    apb(1'b1, 12'h184, 32'h3);
    apb(1'b1, 12'h180, 32'h0);
    // Event interrupt: unmasked, read clears, then masked
    apb(1'b1, 12'h194, 32'h3);
    drive(2'h0);
    apb(1'b0, 12'h190, 32'h0);
    drive(2'h3);
    chk("evt", {31'h0, evt_irq}, 32'h1);
    rdchk("evtstat", 12'h190, 32'h3);
    #1;
    chk("evtclr", {31'h0, evt_irq}, 32'h0);
    apb(1'b1, 12'h194, 32'h0);
    drive(2'h0);
    drive(2'h3);
    chk("evtmask", {31'h0, evt_irq}, 32'h0);
    apb(1'b0, 12'h1F0, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmdata", rd, 32'h0);
    chk("core", 32'(n_irq != 0), 32'h1);
    end_of_test();
  end
endmodule : fast_interrupt_controller_test
